/* rtl/flash_program_erase_controller.sv */
// file: flash program/erase sequencer with block protection, wishbone slave
//
// How it works
// RL1: software writes enables, then picks commit target
// RL2: uncommitted protection bits act immediately
// RL3: commit command stores chosen register permanently
// RL4: word program: data, address, keyed command, poll
// RL5: page erase: address, keyed command, poll
// RL6: mass erase: keyed command, poll, no address
// RL7: command bit high while running, cleared after
// RL8: protection bits only clear on write
// RL9: uncommitted clears restored by power-on reset
// RL10: protection registers loaded from storage at power-on
// RL11: eight block bits, factory value all ones
// RL12: reload field times microsecond tick for pulses
// RL13: software keeps reload at clock MHz minus one
// RL14: software recommended reload value nineteen
// RL15: software aligns word and page addresses
// RL16: thirteen-bit writable offset, upper bits zero
// RL17: write data feeds programming, unused by erase
// RL18: two decode bases for the register windows
// RL19: masked status reads masked, write one clears
// RL20: wrong key ignored, key field reads zero
// RL21: protected reads give zero, protected changes blocked
// RL22: command bit reads one until operation done
// RL23: ticks of reload+1 cycles time every pulse
// RL24: new command refused while one is running
`timescale 1ns/1ps

module flash_program_erase_controller #(
    parameter int WRITE_TICKS = flash_ctrl_pkg::WRITE_TIME_US,
    parameter int ERASE_TICKS = flash_ctrl_pkg::ERASE_TIME_US,
    parameter int MASS_TICKS = flash_ctrl_pkg::MASS_TIME_US,
    parameter int COMMIT_TICKS = flash_ctrl_pkg::COMMIT_TIME_US
) (
    input wire logic sys_clk,
    input wire logic rstn,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // nonvolatile protection store
    input wire logic [7:0] nvReadEnable,
    input wire logic [7:0] nvProgEnable,
    output logic nvCommitStrobe,
    output logic nvCommitSelProg,
    output logic [7:0] nvCommitValue,
    // flash array control
    output logic [12:0] flashAddr,
    output logic [31:0] flashData,
    output logic flashProgram,
    output logic flashErase,
    output logic flashMassErase,
    // data read path toward the array
    input wire logic readReq,
    input wire logic [13:0] readAddr,
    input wire logic [31:0] arrayData,
    output logic [31:0] readData,
    output logic readValid
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic [flash_ctrl_pkg::OFFSET_W-1:0] target_reg; // flash offset
    logic [31:0] wdata_reg; // word to program
    logic [flash_ctrl_pkg::CMD_W-1:0] cmd_reg; // running op bits
    logic [flash_ctrl_pkg::RIS_W-1:0] ris_reg; // raw event status
    logic [flash_ctrl_pkg::RIS_W-1:0] mask_reg; // event mask
    logic [flash_ctrl_pkg::USEC_W-1:0] usec_reg; // tick reload
    logic [flash_ctrl_pkg::TICK_CNT_W-1:0] ticks_reg; // ticks left
    logic loaded_reg; // power-on load has run
    logic commitStrobe_reg; // one cycle commit pulse
    logic [7:0] rdEnable; // live read enables
    logic [7:0] prEnable; // live program enables
    logic tick; // microsecond tick
    logic busy; // an operation is running
    logic opDone; // last tick of the running op
    logic access; // bus request this cycle
    logic busWr; // bus write this cycle
    logic inFlash; // flash window hit
    logic inSysctl; // system control window hit
    logic [11:0] ofs; // offset within window
    logic [31:0] laneMask; // byte enables as a bit mask
    logic [31:0] merged [2]; // lane merge for target/data
    logic cmdWr; // keyed command write
    logic [flash_ctrl_pkg::CMD_W-1:0] startBits; // op to start
    logic blocked; // program or erase on protected block
    logic [flash_ctrl_pkg::BLOCK_W-1:0] tgtBlock; // target block index
    logic [flash_ctrl_pkg::BLOCK_W-1:0] rdBlock; // read block index
    logic [flash_ctrl_pkg::RIS_W-1:0] misc; // masked status
    logic [31:0] rdMux; // read data before the flop

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    // each window matches on the bits above the offset field
    assign inFlash = wb_adr_i[31:flash_ctrl_pkg::BASE_LSB] ==
        flash_ctrl_pkg::FLASH_BASE[31:flash_ctrl_pkg::BASE_LSB]; // RL18
    assign inSysctl = wb_adr_i[31:flash_ctrl_pkg::BASE_LSB] ==
        flash_ctrl_pkg::SYSCTL_BASE[31:flash_ctrl_pkg::BASE_LSB]; // RL18
    assign ofs = wb_adr_i[flash_ctrl_pkg::BASE_LSB-1:0];
    assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign busWr = access && wb_we_i;
    assign laneMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                       {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign merged[0] = ({19'h0_0000, target_reg} & ~laneMask) |
                       (wb_dat_i & laneMask);
    assign merged[1] = (wdata_reg & ~laneMask) | (wb_dat_i & laneMask);

    // ack one cycle after the request, dropped the next; unmapped reads zero
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= access;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // address and data registers

    // offset keeps only its thirteen bits; the rest read back zero
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            target_reg <= '0;
        end else if (busWr && inFlash &&
                     ofs == flash_ctrl_pkg::OFS_TARGET_ADDR) begin
            target_reg <= merged[0][flash_ctrl_pkg::OFFSET_W-1:0]; // RL16
        end
    end

    // write data; erase ignores it, so it may change while erasing
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wdata_reg <= '0;
        end else if (busWr && inFlash &&
                     ofs == flash_ctrl_pkg::OFS_WRITE_DATA) begin
            wdata_reg <= merged[1]; // RL17
        end
    end

    // tick reload, low byte only
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            usec_reg <= flash_ctrl_pkg::USEC_RESET; // RL12
        end else if (busWr && inSysctl && wb_sel_i[0] &&
                     ofs == flash_ctrl_pkg::OFS_USEC_RELOAD) begin
            usec_reg <= wb_dat_i[flash_ctrl_pkg::USEC_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // protection

    // storage is sampled on the first edge after reset is released
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            loaded_reg <= 1'b0;
        end else begin
            loaded_reg <= 1'b1;
        end
    end

    protect_bits #(
        .W(flash_ctrl_pkg::PROT_W),
        .RESET_VALUE(flash_ctrl_pkg::PROT_RESET)
    ) readProt (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .load(!loaded_reg),
        .storedValue(nvReadEnable),
        .wr(busWr && inSysctl && wb_sel_i[0] &&
            ofs == flash_ctrl_pkg::OFS_READ_ENABLE),
        .wrValue(wb_dat_i[flash_ctrl_pkg::PROT_W-1:0]),
        .bits(rdEnable)
    );

    protect_bits #(
        .W(flash_ctrl_pkg::PROT_W),
        .RESET_VALUE(flash_ctrl_pkg::PROT_RESET)
    ) progProt (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .load(!loaded_reg),
        .storedValue(nvProgEnable),
        .wr(busWr && inSysctl && wb_sel_i[0] &&
            ofs == flash_ctrl_pkg::OFS_PROG_ENABLE),
        .wrValue(wb_dat_i[flash_ctrl_pkg::PROT_W-1:0]),
        .bits(prEnable)
    );

    ////////////////////////////////////////////////////////////////////////
    // command decode

    // all four lanes and the key are needed, else the write is dropped
    assign cmdWr = busWr && inFlash && wb_sel_i == 4'hF &&
        ofs == flash_ctrl_pkg::OFS_COMMAND &&
        wb_dat_i[31:flash_ctrl_pkg::KEY_LSB] ==
        flash_ctrl_pkg::WRITE_KEY; // RL20
    assign busy = cmd_reg != '0;
    assign tgtBlock = {1'b0, target_reg[flash_ctrl_pkg::OFFSET_W-1:
                                         flash_ctrl_pkg::BLOCK_LSB]};

    // lowest set bit wins; several bits at once is a software error
    always_comb begin
        startBits = '0;
        blocked = 1'b0;
        if (cmdWr && !busy) begin // RL24
            if (wb_dat_i[flash_ctrl_pkg::CMD_WRITE]) begin
                startBits[flash_ctrl_pkg::CMD_WRITE] = 1'b1;
                blocked = !prEnable[tgtBlock]; // RL21
            end else if (wb_dat_i[flash_ctrl_pkg::CMD_ERASE]) begin
                startBits[flash_ctrl_pkg::CMD_ERASE] = 1'b1;
                blocked = !prEnable[tgtBlock]; // RL21
            end else if (wb_dat_i[flash_ctrl_pkg::CMD_MASS]) begin
                // a mass erase would touch every block
                startBits[flash_ctrl_pkg::CMD_MASS] = 1'b1;
                blocked = prEnable != flash_ctrl_pkg::PROT_RESET; // RL21
            end else if (wb_dat_i[flash_ctrl_pkg::CMD_COMMIT]) begin
                startBits[flash_ctrl_pkg::CMD_COMMIT] = 1'b1; // RL3
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // operation sequencer

    usec_tick_divider #(
        .W(flash_ctrl_pkg::USEC_W)
    ) usecTick (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .run(busy),
        .reload(usec_reg),
        .tick(tick)
    );

    assign opDone = busy && tick && ticks_reg == 1;

    // command bit stays set for the whole pulse and drops on its last tick
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cmd_reg <= '0;
        end else if (startBits != '0 && !blocked) begin
            cmd_reg <= startBits; // RL7 RL22
        end else if (opDone) begin
            cmd_reg <= '0; // RL7 RL22
        end
    end

    // pulse length in whole microsecond ticks
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ticks_reg <= '0;
        end else if (startBits != '0 && !blocked) begin
            unique case (1'b1)
                startBits[flash_ctrl_pkg::CMD_WRITE]:
                    ticks_reg <= WRITE_TICKS[19:0]; // RL23
                startBits[flash_ctrl_pkg::CMD_ERASE]:
                    ticks_reg <= ERASE_TICKS[19:0]; // RL23
                startBits[flash_ctrl_pkg::CMD_MASS]:
                    ticks_reg <= MASS_TICKS[19:0]; // RL23
                default:
                    ticks_reg <= COMMIT_TICKS[19:0]; // RL23
            endcase
        end else if (busy && tick) begin
            ticks_reg <= ticks_reg - 1'b1;
        end
    end

    // commit hands the chosen live register to storage once
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            commitStrobe_reg <= 1'b0;
            nvCommitSelProg <= 1'b0;
            nvCommitValue <= flash_ctrl_pkg::PROT_RESET;
        end else begin
            commitStrobe_reg <= startBits[flash_ctrl_pkg::CMD_COMMIT];
            if (startBits[flash_ctrl_pkg::CMD_COMMIT]) begin
                nvCommitSelProg <= target_reg[0]; // RL3
                nvCommitValue <= target_reg[0] ? prEnable : rdEnable; // RL3
            end
        end
    end

    assign nvCommitStrobe = commitStrobe_reg;
    assign flashAddr = target_reg;
    assign flashData = wdata_reg;
    assign flashProgram = cmd_reg[flash_ctrl_pkg::CMD_WRITE];
    assign flashErase = cmd_reg[flash_ctrl_pkg::CMD_ERASE];
    assign flashMassErase = cmd_reg[flash_ctrl_pkg::CMD_MASS];

    ////////////////////////////////////////////////////////////////////////
    // data reads

    assign rdBlock = readAddr[flash_ctrl_pkg::ARRAY_ADDR_W-1:
                              flash_ctrl_pkg::BLOCK_LSB];

    // read-protected blocks answer all zeros, one cycle later
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            readData <= '0;
            readValid <= 1'b0;
        end else begin
            readValid <= readReq;
            readData <= (readReq && rdEnable[rdBlock]) ? arrayData
                                                       : '0; // RL21
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // event status

    // a new event in the clearing cycle survives: set beats clear
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ris_reg <= '0;
        end else begin
            for (int i = 0; i < flash_ctrl_pkg::RIS_W; i++) begin
                if ((i == flash_ctrl_pkg::RIS_PROG && opDone) ||
                    (i == flash_ctrl_pkg::RIS_ACCESS &&
                     (blocked || (readReq && !rdEnable[rdBlock])))) begin
                    ris_reg[i] <= 1'b1;
                end else if (busWr && inFlash && wb_sel_i[0] &&
                             ofs == flash_ctrl_pkg::OFS_MASKED_IRQ &&
                             wb_dat_i[i]) begin
                    ris_reg[i] <= 1'b0; // RL19
                end
            end
        end
    end

    // event mask
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mask_reg <= '0;
        end else if (busWr && inFlash && wb_sel_i[0] &&
                     ofs == flash_ctrl_pkg::OFS_IRQ_MASK) begin
            mask_reg <= wb_dat_i[flash_ctrl_pkg::RIS_W-1:0];
        end
    end

    assign misc = ris_reg & mask_reg; // RL19

    ////////////////////////////////////////////////////////////////////////
    // register readback

    // key field and reserved bits read zero
    always_comb begin
        rdMux = '0;
        if (inFlash) begin
            unique case (ofs)
                flash_ctrl_pkg::OFS_TARGET_ADDR: rdMux = {19'h0_0000, target_reg};
                flash_ctrl_pkg::OFS_WRITE_DATA: rdMux = wdata_reg;
                flash_ctrl_pkg::OFS_COMMAND: rdMux = {28'h000_0000, cmd_reg}; // RL20
                flash_ctrl_pkg::OFS_RAW_IRQ: rdMux = {30'h0000_0000, ris_reg};
                flash_ctrl_pkg::OFS_IRQ_MASK: rdMux = {30'h0000_0000, mask_reg};
                flash_ctrl_pkg::OFS_MASKED_IRQ: rdMux = {30'h0000_0000, misc};
                default: rdMux = '0;
            endcase
        end else if (inSysctl) begin
            unique case (ofs)
                flash_ctrl_pkg::OFS_READ_ENABLE: rdMux = {24'h00_0000, rdEnable};
                flash_ctrl_pkg::OFS_PROG_ENABLE: rdMux = {24'h00_0000, prEnable};
                flash_ctrl_pkg::OFS_USEC_RELOAD: rdMux = {24'h00_0000, usec_reg};
                default: rdMux = '0;
            endcase
        end
    end

    // read data registered together with ack
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wb_dat_o <= '0;
        end else if (access) begin
            wb_dat_o <= rdMux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    ack_single_pulse_a: assert property ( // RL18
        @(posedge sys_clk) disable iff (!rstn)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    key_reject_idle_a: assert property ( // RL20
        @(posedge sys_clk) disable iff (!rstn)
        (!busy && busWr && inFlash && ofs == flash_ctrl_pkg::OFS_COMMAND &&
         wb_dat_i[31:16] != flash_ctrl_pkg::WRITE_KEY) |=> !busy)
        else $error("command started without the key");

    busy_hold_a: assert property ( // RL24
        @(posedge sys_clk) disable iff (!rstn)
        (busy && !opDone) |=> cmd_reg == $past(cmd_reg))
        else $error("running command bits changed");

    prot_only_clear_a: assert property ( // RL8
        @(posedge sys_clk) disable iff (!rstn)
        $past(loaded_reg) |-> ((rdEnable & ~$past(rdEnable)) == '0 &&
                               (prEnable & ~$past(prEnable)) == '0))
        else $error("protection bit raised by a write");

    done_sets_status_a: assert property ( // RL7
        @(posedge sys_clk) disable iff (!rstn)
        opDone |=> !busy && ris_reg[flash_ctrl_pkg::RIS_PROG])
        else $error("finished op did not clear bit and flag");

    blocked_no_start_a: assert property ( // RL21
        @(posedge sys_clk) disable iff (!rstn)
        blocked |=> !busy ##0 ris_reg[flash_ctrl_pkg::RIS_ACCESS])
        else $error("protected block change was started");

    read_zero_a: assert property ( // RL21
        @(posedge sys_clk) disable iff (!rstn)
        (readReq && !rdEnable[rdBlock]) |=> readValid && readData == '0)
        else $error("protected read returned data");

    commit_pulse_a: assert property ( // RL3
        @(posedge sys_clk) disable iff (!rstn)
        startBits[flash_ctrl_pkg::CMD_COMMIT] |=>
            nvCommitStrobe && cmd_reg[flash_ctrl_pkg::CMD_COMMIT] ##1
            !nvCommitStrobe)
        else $error("commit strobe not a single pulse");

    tick_spacing_a: assert property ( // RL23
        @(posedge sys_clk) disable iff (!rstn)
        (tick && busy && usec_reg != '0) |=> !tick)
        else $error("tick period shorter than reload plus one");

endmodule : flash_program_erase_controller

/* rtl/flash_ctrl_pkg.sv */
// package: register map, field layout and timing constants of the flash controller
package flash_ctrl_pkg;

    // bus bases of the two register windows
    localparam logic [31:0] FLASH_BASE = 32'h400F_D000;
    localparam logic [31:0] SYSCTL_BASE = 32'h400F_E000;
    localparam int BASE_LSB = 12; // offsets live below this bit

    // register offsets inside each window
    localparam logic [11:0] OFS_TARGET_ADDR = 12'h000;
    localparam logic [11:0] OFS_WRITE_DATA = 12'h004;
    localparam logic [11:0] OFS_COMMAND = 12'h008;
    localparam logic [11:0] OFS_RAW_IRQ = 12'h00C;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h010;
    localparam logic [11:0] OFS_MASKED_IRQ = 12'h014;
    localparam logic [11:0] OFS_READ_ENABLE = 12'h130;
    localparam logic [11:0] OFS_PROG_ENABLE = 12'h134;
    localparam logic [11:0] OFS_USEC_RELOAD = 12'h140;

    // field layout
    localparam int OFFSET_W = 13; // target offset width
    localparam int BLOCK_LSB = 11; // 2 KB protection block
    localparam int BLOCK_W = 3; // eight blocks
    localparam int ARRAY_ADDR_W = 14; // 16 KB array, byte address
    localparam int PROT_W = 8;
    localparam int USEC_W = 8;
    localparam int KEY_LSB = 16;
    localparam logic [15:0] WRITE_KEY = 16'hA442;
    localparam int CMD_W = 4;
    localparam int CMD_WRITE = 0;
    localparam int CMD_ERASE = 1;
    localparam int CMD_MASS = 2;
    localparam int CMD_COMMIT = 3;
    localparam int RIS_W = 2;
    localparam int RIS_ACCESS = 0;
    localparam int RIS_PROG = 1;

    // reset values
    localparam logic [7:0] PROT_RESET = 8'hFF;
    localparam logic [7:0] USEC_RESET = 8'h13;

    // pulse lengths in microseconds (one divider tick each)
    localparam int WRITE_TIME_US = 50;
    localparam int ERASE_TIME_US = 25000;
    localparam int MASS_TIME_US = 250000;
    localparam int COMMIT_TIME_US = 50;
    localparam int TICK_CNT_W = 20;

endpackage : flash_ctrl_pkg

/* rtl/usec_tick_divider.sv */
// file: microsecond tick divider reloaded from the reload register
`timescale 1ns/1ps

module usec_tick_divider #(
    parameter int W = 8 // reload width
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic run, // count only while an operation runs
    input wire logic [W-1:0] reload, // cycles per tick minus one
    output logic tick // one cycle pulse per microsecond
);

    logic [W-1:0] cnt_reg; // cycles left in this tick

    // restart from the reload value whenever idle so every op starts aligned
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= '0;
        end else if (!run || cnt_reg == '0) begin
            cnt_reg <= reload; // RL23
        end else begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    // a tick every reload+1 cycles
    assign tick = run && (cnt_reg == '0); // RL12

endmodule : usec_tick_divider

/* rtl/protect_bits.sv */
// file: one protection register, loaded at power-on and clearable only
`timescale 1ns/1ps

module protect_bits #(
    parameter int W = 8,
    parameter logic [W-1:0] RESET_VALUE = '1
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic load, // power-on reload from storage
    input wire logic [W-1:0] storedValue, // nonvolatile copy
    input wire logic wr, // bus write strobe
    input wire logic [W-1:0] wrValue, // bits written (byte lane 0 of the bus data)
    output logic [W-1:0] bits // live enables
);

    // a written 0 clears, a written 1 keeps the old bit
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            bits <= RESET_VALUE; // RL11
        end else if (load) begin
            bits <= storedValue; // RL10 RL9
        end else if (wr) begin
            bits <= bits & wrValue; // RL8 RL2
        end
    end

endmodule : protect_bits

/* verification/flash_array_model.sv */
// partner model: nonvolatile protection store and flash array read data
`timescale 1ns/1ps

module flash_array_model (
    input wire logic sys_clk,
    input wire logic nvCommitStrobe,
    input wire logic nvCommitSelProg,
    input wire logic [7:0] nvCommitValue,
    input wire logic [13:0] readAddr,
    // factory state opens every block; no reset touches it
    output logic [7:0] nvReadEnable = 8'hFF,
    output logic [7:0] nvProgEnable = 8'hFF,
    output logic [31:0] arrayData
);
    ////////////////////////////////////////////////////////////
    // a commit pulse makes the chosen register permanent
    always @(posedge sys_clk) begin
        if (nvCommitStrobe && nvCommitSelProg) nvProgEnable <= nvCommitValue;
        if (nvCommitStrobe && !nvCommitSelProg) nvReadEnable <= nvCommitValue;
    end
    // word follows the address, so a wrong block shows up at once
    assign arrayData = 32'h5A5A_0000 | {18'h0, readAddr};
endmodule : flash_array_model

/* verification/flash_program_erase_controller_tb_top.sv */
// testbench: register, command and protection scenarios
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    failures++; $display("MISMATCH %s exp %h got %h", n, e, g); end end

module flash_program_erase_controller_tb_top;
    localparam logic [31:0] FB = flash_ctrl_pkg::FLASH_BASE;
    localparam logic [31:0] SB = flash_ctrl_pkg::SYSCTL_BASE;
    logic sysClk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, readReq = 0;
    logic [31:0] adr = '0, dat = '0, q, wbDat, arrayData, readData, flashData;
    logic [13:0] readAddr = '0;
    logic ack, readValid, commitStrobe, commitSel, prog, erase, mass;
    logic [7:0] nvRe, nvPe, commitVal;
    logic [12:0] flashAddr;
    int failures = 0, comparisons = 0;

    always #25 sysClk = ~sysClk;

    // short pulse counts keep the mass erase within a few hundred cycles
    flash_program_erase_controller #(.WRITE_TICKS(3), .ERASE_TICKS(5),
        .MASS_TICKS(7), .COMMIT_TICKS(2)) flash_program_erase_controller_i (
        .sys_clk(sysClk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
        .wb_dat_o(wbDat), .wb_ack_o(ack), .nvReadEnable(nvRe),
        .nvProgEnable(nvPe), .nvCommitStrobe(commitStrobe),
        .nvCommitSelProg(commitSel), .nvCommitValue(commitVal),
        .flashAddr(flashAddr), .flashData(flashData), .flashProgram(prog),
        .flashErase(erase), .flashMassErase(mass), .readReq(readReq),
        .readAddr(readAddr), .arrayData(arrayData), .readData(readData),
        .readValid(readValid));
    flash_array_model flash_array_model_i (.sys_clk(sysClk),
        .nvCommitStrobe(commitStrobe), .nvCommitSelProg(commitSel),
        .nvCommitValue(commitVal), .readAddr(readAddr), .nvReadEnable(nvRe),
        .nvProgEnable(nvPe), .arrayData(arrayData));

    ////////////////////////////////////////////////////////////
    task finish_test;
        if (failures == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test
    // one classic cycle; request held until ack is seen at an edge
    task automatic bus(input logic w, input logic [31:0] a, d);
        int n;
        @(posedge sysClk);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        n = 0;
        do begin
            @(posedge sysClk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = wbDat;
        {cyc, stb} <= 2'b00;
        if (n >= 20) begin
            failures++;
            finish_test;
        end
    endtask : bus
    task automatic rdc(input logic [31:0] a, e, input string n);
        bus(1'b0, a, 32'h0);
        `CHK(n, e, q)
    endtask : rdc
    // reset is held twelve cycles; no request in the reload cycle
    task do_reset;
        rstn <= 1'b0;
        repeat (12) @(posedge sysClk);
        rstn <= 1'b1;
        repeat (2) @(posedge sysClk);
    endtask : do_reset
    // polling gives up after a fixed count of reads
    task automatic poll(input int b);
        int n;
        n = 0;
        do begin
            bus(1'b0, FB + 32'h8, 32'h0);
            n++;
        end while (q[b] !== 1'b0 && n < 60);
        `CHK("cmdBit", 1'b0, q[b])
        if (n >= 60) finish_test;
    endtask : poll
    task automatic dread(input logic [13:0] a, input logic [31:0] e);
        @(posedge sysClk);
        {readReq, readAddr} <= {1'b1, a};
        @(posedge sysClk);
        readReq <= 1'b0;
        @(posedge sysClk);
        `CHK("readValid", 1'b1, readValid)
        `CHK("readData", e, readData)
    endtask : dread

    ////////////////////////////////////////////////////////////
    task s_reset;
        rdc(SB + 32'h140, 32'h13, "reload");
        rdc(SB + 32'h130, 32'hFF, "readEn");
        rdc(SB + 32'h134, 32'hFF, "progEn");
        rdc(FB, 32'h0, "target");
        rdc(FB + 32'h20, 32'h0, "unmapped");
    endtask : s_reset
    task s_protect;
        bus(1'b1, FB, 32'hFFFF_FFFF);
        rdc(FB, 32'h0000_1FFF, "target");
        bus(1'b1, SB + 32'h130, 32'h0000_00FE);
        bus(1'b1, SB + 32'h130, 32'h0000_00FF);
        rdc(SB + 32'h130, 32'hFE, "readEn");
        dread(14'h0004, 32'h0);
        dread(14'h0804, 32'h5A5A_0804);
    endtask : s_protect
    // twenty cycles a tick leaves room to probe a running operation
    task automatic s_ops;
        bus(1'b1, FB + 32'h8, 32'h1);
        rdc(FB + 32'h8, 32'h0, "noKey");
        bus(1'b1, SB + 32'h140, 32'h1);
        rdc(SB + 32'h140, 32'h1, "reload");
        bus(1'b1, SB + 32'h140, 32'h13);
        bus(1'b1, FB + 32'h4, 32'h1234_5678);
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, FB, 32'h0000_0C00);
            bus(1'b1, FB + 32'h8, 32'hA442_0000 | (32'h1 << i));
            rdc(FB + 32'h8, 32'h1 << i, "running");
            `CHK("flashAddr", 13'h0C00, flashAddr)
            `CHK("levels", 3'h1 << i, {mass, erase, prog})
            `CHK("flashData", 32'h1234_5678, flashData)
            bus(1'b1, FB + 32'h8, 32'hA442_0008);
            rdc(FB + 32'h8, 32'h1 << i, "refused");
            poll(i);
        end
        rdc(FB + 32'hC, 32'h3, "rawStat");
        bus(1'b1, FB + 32'h10, 32'h2);
        rdc(FB + 32'h14, 32'h2, "maskStat");
        bus(1'b1, FB + 32'h14, 32'h3);
        rdc(FB + 32'hC, 32'h0, "cleared");
    endtask : s_ops
    task s_commit;
        bus(1'b1, SB + 32'h134, 32'h0000_00FD);
        bus(1'b1, FB, 32'h0);
        bus(1'b1, FB + 32'h8, 32'hA442_0008);
        poll(3);
        `CHK("nvRe", 8'hFE, nvRe)
        do_reset;
        rdc(SB + 32'h130, 32'hFE, "readEn");
        rdc(SB + 32'h134, 32'hFF, "progEn");
        bus(1'b1, SB + 32'h134, 32'h0000_00FE);
        bus(1'b1, FB + 32'h8, 32'hA442_0001);
        rdc(FB + 32'h8, 32'h0, "blocked");
        rdc(FB + 32'hC, 32'h1, "rawStat");
    endtask : s_commit

    initial begin
        do_reset;
        s_reset;
        s_protect;
        s_ops;
        s_commit;
        finish_test;
    end
endmodule : flash_program_erase_controller_tb_top
